// ==== core/ccs_pkg.sv ====
package ccs_pkg;
    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [3:0] OP_OPT_Q = 4'h0;
    localparam logic [3:0] OP_PSC   = 4'h1;
    localparam logic [3:0] OP_PSC_Q = 4'h2;
    localparam logic [3:0] OP_RCL   = 4'h3;
    localparam logic [3:0] OP_SAV   = 4'h4;
    localparam logic [3:0] OP_RST   = 4'h5;
    localparam logic [3:0] OP_SRE   = 4'h6;
    localparam logic [3:0] OP_SRE_Q = 4'h7;
    localparam logic [3:0] OP_STB_Q = 4'h8;
    localparam logic [3:0] OP_TRG   = 4'h9;
    localparam logic [3:0] OP_WAI   = 4'hA;
    localparam logic [3:0] OP_OPC   = 4'hB;
    localparam logic [3:0] OP_ESE   = 4'hC;
    localparam logic [3:0] OP_ESE_Q = 4'hD;
    localparam logic [3:0] OP_ESR_Q = 4'hE;

    // ----------------------------------------------------------------
    // status byte and event register layout
    // ----------------------------------------------------------------
    localparam int STB_OPER = 7;
    localparam int STB_MSS  = 6;
    localparam int STB_ESB  = 5;
    localparam int STB_MAV  = 4;
    localparam int STB_QUES = 3;
    localparam int ESR_OPC  = 0;
    localparam logic [7:0] ESR_USED  = 8'hBD;
    localparam logic [7:0] SRE_RESET = 8'h00;
    localparam logic [7:0] ESE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // slots, options, settings word
    // ----------------------------------------------------------------
    localparam int NUM_SLOTS = 8;
    localparam int NUM_OPT   = 14;
    localparam int STATE_W   = 47;
    localparam int SW_CONT   = 0;
    localparam int SW_OUT    = 1;
    localparam int SW_LIST   = 2;
    localparam int SW_PDLY   = 3;
    localparam int SW_FREQ   = 19;
    localparam int SW_TSRC   = 35;
    localparam int SW_SSRC   = 36;
    localparam int SW_SPHS   = 37;
    localparam int SW_SLEW   = 46;
    localparam logic [15:0] DEF_PDLY_MS = 16'h0064;
    localparam logic [15:0] DEF_FREQ_HZ = 16'h003C;
    localparam logic [8:0]  DEF_SPHS    = 9'h000;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_IDLE = 3'b010,
        ST_OPT  = 3'b100
    } ccs_state_t;

    function automatic logic [STATE_W-1:0] ccs_defaults();
        logic [STATE_W-1:0] w;
        w = '0;
        w[SW_LIST] = 1'b1;
        w[SW_PDLY +: 16] = DEF_PDLY_MS;
        w[SW_FREQ +: 16] = DEF_FREQ_HZ;
        w[SW_TSRC] = 1'b1;
        w[SW_SSRC] = 1'b1;
        w[SW_SPHS +: 9] = DEF_SPHS;
        w[SW_SLEW] = 1'b1;
        return w;
    endfunction
endpackage

// ==== core/ccs_slot_store.sv ====
module ccs_slot_store
    import ccs_pkg::*;
#(
    parameter int W     = ccs_pkg::STATE_W,
    parameter int SLOTS = ccs_pkg::NUM_SLOTS
) (
    input  wire logic                     mclk,
    input  wire logic                     arst_n,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    input  wire logic [$clog2(SLOTS)-1:0] slot,
    input  wire logic [W-1:0]             wr_data,
    output logic      [W-1:0]             rd_data,
    output logic                          rd_valid
);
    // nonvolatile slots: no reset, contents survive power cycling
    logic [W-1:0] mem [SLOTS];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[slot] <= wr_data;
        end
        rd_data <= mem[slot];
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
        end
    end
endmodule

// ==== core/ccs_nv_cfg.sv ====
module ccs_nv_cfg (
    input  wire logic       mclk,
    input  wire logic       psc_we,
    input  wire logic       psc_d,
    input  wire logic       mask_we,
    input  wire logic [7:0] sre_d,
    input  wire logic [7:0] ese_d,
    output logic            psc_q,
    output logic [7:0]      sre_q,
    output logic [7:0]      ese_q
);
    // nonvolatile cells, deliberately not touched by reset
    always_ff @(posedge mclk) begin
        if (psc_we) begin
            psc_q <= psc_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (mask_we) begin
            sre_q <= sre_d;
            ese_q <= ese_d;
        end
    end
endmodule

// ==== core/ccs_common_cmd.sv ====
// How it works
// - option query lists keyword or zero per feature
// - clear-at-power-on set: masks cleared at power-up
// - clear-at-power-on off: masks restored from storage
// - recall restores saved state from slots 0-7
// - recall forces calibration off and aborts trigger
// - save stores present state into one slot
// - reset loads factory default settings word
// - reset behaves exactly like device clear
// - reset clears status, keeps enable masks
// - enabled status bits ORed into bit 6
// - zero request mask never raises a request
// - request mask defaults to zero
// - status byte bit layout fixed
// - status byte query never clears bits
// - event register bits cleared only by event reads, reset or device clear
// - serial poll shows request flag in bit 6
// - serial poll clears request flag, keeps summary
// - trigger command pulses bus trigger
// - wait holds off until overlapped work done
// - any later command except a wait with work pending ends the wait hold-off
// - completion command sets event bit 0, non-blocking
module ccs_common_cmd
    import ccs_pkg::*;
#(
    parameter int NOPT = ccs_pkg::NUM_OPT,
    parameter int SW   = ccs_pkg::STATE_W
) (
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire logic                  cmd_valid,
    input  wire logic [3:0]            cmd_op,
    input  wire logic [7:0]            cmd_arg,
    input  wire logic                  dev_clear,
    input  wire logic                  serial_poll,
    input  wire logic                  pending_ops,
    input  wire logic [7:0]            std_event_set,
    input  wire logic                  oper_summary,
    input  wire logic                  ques_summary,
    input  wire logic                  msg_avail,
    input  wire logic [NOPT-1:0]       opt_installed,
    input  wire logic [SW-1:0]         inst_state,
    output logic                       cmd_ready,
    output logic                       resp_valid,
    output logic      [7:0]            resp_data,
    output logic                       poll_valid,
    output logic      [7:0]            poll_data,
    output logic                       srq,
    output logic      [7:0]            status_byte,
    output logic                       settings_load,
    output logic      [SW-1:0]         settings_word,
    output logic                       cal_off,
    output logic                       trig_abort,
    output logic                       bus_trigger,
    output logic                       clear_status,
    output logic                       hold_off
);
    import ccs_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ccs_state_t        st_r;
    ccs_state_t        st_nxt;
    logic [7:0]        sre_r;
    logic [7:0]        ese_r;
    logic [7:0]        esr_r;
    logic              rqs_r;
    logic              mss_prev_r;
    logic              opc_arm_r;
    logic [4:0]        opt_idx_r;
    logic              take;
    logic              status_clr;
    logic              sre_wr;
    logic              mss;
    logic              mss_rise;
    logic              opc_done;
    logic [7:0]        stb_now;
    logic [7:0]        opt_entry;
    logic              rcl_ok;
    logic              nv_psc;
    logic [7:0]        nv_sre;
    logic [7:0]        nv_ese;
    logic              nv_psc_we;
    logic              nv_mask_we;
    logic              nv_psc_d;
    logic [7:0]        nv_sre_d;
    logic [7:0]        nv_ese_d;
    logic [SW-1:0]     slot_data;
    logic              slot_valid;

    assign take       = cmd_valid && cmd_ready;
    assign status_clr = dev_clear || (take && cmd_op == OP_RST);
    assign sre_wr     = take && cmd_op == OP_SRE;
    assign rcl_ok     = take && cmd_op == OP_RCL && cmd_arg < 8'h08;

    // ----------------------------------------------------------------
    // status byte
    // ----------------------------------------------------------------
    always_comb begin
        stb_now           = 8'h00;
        stb_now[STB_OPER] = oper_summary;
        stb_now[STB_ESB]  = |(esr_r & ese_r);
        stb_now[STB_MAV]  = msg_avail;
        stb_now[STB_QUES] = ques_summary;
        mss               = |(stb_now & sre_r);
        stb_now[STB_MSS]  = mss;
    end

    assign mss_rise = mss && !mss_prev_r;
    assign opc_done = opc_arm_r && !pending_ops;

    // option entry: fixed order, index+1 as keyword code, zero if absent
    assign opt_entry = opt_installed[opt_idx_r[3:0]] ?
                       8'(opt_idx_r) + 8'h01 : 8'h00;

    // ----------------------------------------------------------------
    // nonvolatile mask storage and slots
    // ----------------------------------------------------------------
    // masks are saved only while clear-at-power-on is off
    assign nv_psc_we  = take && cmd_op == OP_PSC;
    assign nv_psc_d   = cmd_arg != 8'h00;
    assign nv_mask_we = take && (cmd_op == OP_SRE || cmd_op == OP_ESE ||
                        cmd_op == OP_PSC) &&
                        ((cmd_op == OP_PSC) ? !nv_psc_d : !nv_psc);
    assign nv_sre_d   = (cmd_op == OP_SRE) ? cmd_arg : sre_r;
    assign nv_ese_d   = (cmd_op == OP_ESE) ? cmd_arg : ese_r;

    ccs_nv_cfg u_nv (
        .mclk    (mclk),
        .psc_we  (nv_psc_we),
        .psc_d   (nv_psc_d),
        .mask_we (nv_mask_we),
        .sre_d   (nv_sre_d),
        .ese_d   (nv_ese_d),
        .psc_q   (nv_psc),
        .sre_q   (nv_sre),
        .ese_q   (nv_ese)
    );

    ccs_slot_store #(
        .W     (SW),
        .SLOTS (NUM_SLOTS)
    ) u_slots (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .wr_en    (take && cmd_op == OP_SAV && cmd_arg < 8'h08),
        .rd_en    (rcl_ok),
        .slot     (cmd_arg[2:0]),
        .wr_data  (inst_state),
        .rd_data  (slot_data),
        .rd_valid (slot_valid)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_BOOT: st_nxt = ST_IDLE;
            ST_IDLE: begin
                if (take && cmd_op == OP_OPT_Q) begin
                    st_nxt = ST_OPT;
                end
            end
            ST_OPT: begin
                if (opt_idx_r == 5'(NOPT - 1)) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_r      <= ST_BOOT;
            cmd_ready <= 1'b0;
            opt_idx_r <= 5'h00;
        end else begin
            st_r      <= st_nxt;
            cmd_ready <= (st_nxt == ST_IDLE);
            opt_idx_r <= (st_r == ST_OPT) ? opt_idx_r + 5'h01 : 5'h00;
        end
    end

    // ----------------------------------------------------------------
    // enable masks
    // ----------------------------------------------------------------
    // power-up state is zero; restore runs one cycle after release
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sre_r <= SRE_RESET;
            ese_r <= ESE_RESET;
        end else if (st_r == ST_BOOT) begin
            sre_r <= nv_psc ? SRE_RESET : nv_sre;
            ese_r <= nv_psc ? ESE_RESET : nv_ese;
        end else if (take && cmd_op == OP_SRE) begin
            sre_r <= cmd_arg;
        end else if (take && cmd_op == OP_ESE) begin
            ese_r <= cmd_arg;
        end
    end

    // ----------------------------------------------------------------
    // standard event register, completion tracking
    // ----------------------------------------------------------------
    // a new event in the clearing cycle survives: set wins
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            esr_r <= 8'h00;
        end else begin
            esr_r <= (((status_clr || (take && cmd_op == OP_ESR_Q)) ?
                      8'h00 : esr_r) | std_event_set |
                      {7'h00, opc_done}) & ESR_USED;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            opc_arm_r <= 1'b0;
        end else if (take && cmd_op == OP_OPC) begin
            opc_arm_r <= 1'b1;
        end else if (opc_done || status_clr) begin
            opc_arm_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // service request
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rqs_r      <= 1'b0;
            mss_prev_r <= 1'b0;
        end else begin
            mss_prev_r <= mss;
            // writing a zero mask must kill any pending request
            if (sre_wr && cmd_arg == 8'h00) begin
                rqs_r <= 1'b0;
            end else if (mss_rise && !status_clr) begin
                rqs_r <= 1'b1;
            end else if (serial_poll || status_clr) begin
                rqs_r <= 1'b0;
            end
        end
    end

    assign srq = rqs_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            poll_valid  <= 1'b0;
            poll_data   <= 8'h00;
            status_byte <= 8'h00;
        end else begin
            poll_valid  <= serial_poll;
            poll_data   <= {stb_now[7], rqs_r, stb_now[5:0]};
            status_byte <= stb_now;
        end
    end

    // ----------------------------------------------------------------
    // query answers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            resp_valid <= 1'b0;
            resp_data  <= 8'h00;
        end else if (st_r == ST_OPT) begin
            resp_valid <= 1'b1;
            resp_data  <= opt_entry;
        end else begin
            resp_valid <= take && (cmd_op == OP_PSC_Q ||
                          cmd_op == OP_SRE_Q || cmd_op == OP_STB_Q ||
                          cmd_op == OP_ESE_Q || cmd_op == OP_ESR_Q);
            unique case (cmd_op)
                OP_PSC_Q: resp_data <= {7'h00, nv_psc};
                OP_SRE_Q: resp_data <= sre_r;
                OP_STB_Q: resp_data <= stb_now;
                OP_ESE_Q: resp_data <= ese_r;
                OP_ESR_Q: resp_data <= esr_r;
                default:  resp_data <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // settings, trigger, hold-off
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            settings_load <= 1'b0;
            settings_word <= ccs_defaults();
        end else if (status_clr) begin
            settings_load <= 1'b1;
            settings_word <= ccs_defaults();
        end else begin
            settings_load <= slot_valid;
            if (slot_valid) begin
                settings_word <= slot_data;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cal_off      <= 1'b0;
            trig_abort   <= 1'b0;
            bus_trigger  <= 1'b0;
            clear_status <= 1'b0;
        end else begin
            cal_off      <= rcl_ok;
            trig_abort   <= rcl_ok;
            bus_trigger  <= take && cmd_op == OP_TRG;
            clear_status <= status_clr;
        end
    end

    // hold-off ends on completion or on any later command except a wait with work pending
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hold_off <= 1'b0;
        end else if (take) begin
            hold_off <= (cmd_op == OP_WAI) && pending_ops;
        end else if (!pending_ops || status_clr) begin
            hold_off <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_rcl_pulse;
        cal_off && trig_abort;
    endsequence
    sequence s_rcl_load;
        settings_load && settings_word == $past(slot_data);
    endsequence

    property p_opt_entry;
        @(posedge mclk) disable iff (!arst_n)
        st_r == ST_OPT |=> resp_valid && resp_data == $past(opt_entry);
    endproperty
    a_opt_entry: assert property (p_opt_entry)
        else $error("option entry wrong");

    property p_boot_mask;
        @(posedge mclk) disable iff (!arst_n)
        st_r == ST_BOOT |=> sre_r === ($past(nv_psc) ? 8'h00 : $past(nv_sre));
    endproperty
    a_boot_mask: assert property (p_boot_mask)
        else $error("power-up mask restore wrong");

    property p_rcl;
        @(posedge mclk) disable iff (!arst_n)
        rcl_ok && !status_clr ##1 !status_clr |-> s_rcl_pulse ##1 s_rcl_load;
    endproperty
    a_rcl: assert property (p_rcl)
        else $error("recall sequence wrong");

    property p_rst;
        @(posedge mclk) disable iff (!arst_n)
        status_clr |=> settings_load && clear_status &&
                       settings_word == ccs_defaults();
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset defaults not loaded");

    property p_sre_zero;
        @(posedge mclk) disable iff (!arst_n)
        sre_r == 8'h00 && $past(sre_r) == 8'h00 && st_r != ST_BOOT |-> !srq;
    endproperty
    a_sre_zero: assert property (p_sre_zero)
        else $error("request raised with zero mask");

    property p_poll;
        @(posedge mclk) disable iff (!arst_n)
        serial_poll && !mss_rise && !sre_wr |=>
            poll_valid && !srq && poll_data[STB_MSS] == $past(rqs_r);
    endproperty
    a_poll: assert property (p_poll)
        else $error("serial poll answer wrong");

    property p_rqs_rise;
        @(posedge mclk) disable iff (!arst_n)
        mss_rise && !status_clr && !sre_wr |=> srq;
    endproperty
    a_rqs_rise: assert property (p_rqs_rise)
        else $error("summary rise did not request");

    property p_wai;
        @(posedge mclk) disable iff (!arst_n)
        hold_off && take |=> !hold_off || $past(cmd_op) == OP_WAI;
    endproperty
    a_wai: assert property (p_wai)
        else $error("hold-off not cancelled");

    property p_opc;
        @(posedge mclk) disable iff (!arst_n)
        opc_done |=> esr_r[ESR_OPC] && cmd_ready == $past(st_nxt == ST_IDLE);
    endproperty
    a_opc: assert property (p_opc)
        else $error("completion bit not set");

    property p_stb;
        @(posedge mclk) disable iff (!arst_n)
        take && cmd_op == OP_STB_Q |=> resp_data == $past(stb_now) &&
            status_byte[STB_MSS] == |($past(stb_now) & $past(sre_r));
    endproperty
    a_stb: assert property (p_stb)
        else $error("status byte answer wrong");

    property p_trg;
        @(posedge mclk) disable iff (!arst_n)
        bus_trigger == $past(take && cmd_op == OP_TRG);
    endproperty
    a_trg: assert property (p_trg)
        else $error("bus trigger not pulsed");
endmodule

// ==== dv/ccs_ctrl_model.sv ====
// ------------------------------------------------------------
// remote controller: commands and serial polls
// ------------------------------------------------------------
module ccs_ctrl_model (
    input  wire logic       mclk,
    input  wire logic       cmd_ready,
    output logic            cmd_valid,
    output logic      [3:0] cmd_op,
    output logic      [7:0] cmd_arg,
    output logic            serial_poll
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cmd_valid   = 1'b0;
        cmd_op      = 4'hF;
        cmd_arg     = 8'h00;
        serial_poll = 1'b0;
    end

    // held until the edge that sees ready; released lines show the inverse
    task automatic send(input logic [3:0] op, input logic [7:0] arg);
        @(posedge mclk);
        #1;
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_arg   = arg;
        do @(posedge mclk); while (cmd_ready !== 1'b1);
        #1;
        cmd_valid = 1'b0;
        cmd_op    = ~op;
        cmd_arg   = ~arg;
    endtask

    task automatic poll();
        @(posedge mclk);
        #1;
        serial_poll = 1'b1;
        @(posedge mclk);
        #1;
        serial_poll = 1'b0;
    endtask
endmodule

// ==== dv/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ccs_pkg::*;

    logic                mclk = 1'b0;
    logic                arst_n = 1'b0;
    logic                dev_clear = 1'b0;
    logic                pending_ops = 1'b0;
    logic                oper_summary = 1'b0;
    logic                ques_summary = 1'b0;
    logic                msg_avail = 1'b0;
    logic [NUM_OPT-1:0]  opt_installed = '0;
    logic [STATE_W-1:0]  inst_state = '0;
    logic [STATE_W-1:0]  settings_word, dflt;
    logic [7:0]          resp_data, poll_data, status_byte, d;
    logic [7:0]          poll_last, resp_q[$];
    logic [3:0]          cmd_op;
    logic [7:0]          cmd_arg;
    logic                cmd_valid, serial_poll, cmd_ready, resp_valid;
    logic                poll_valid, srq, settings_load, cal_off;
    logic                trig_abort, bus_trigger, clear_status, hold_off;
    int                  fails, check_count, n_trig, n_clr, n_load, n_cal;

    always #50 mclk = ~mclk;

    ccs_ctrl_model i_ccs_ctrl_model (.mclk(mclk), .cmd_ready(cmd_ready),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
        .serial_poll(serial_poll));

    ccs_common_cmd i_ccs_common_cmd (.mclk(mclk), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
        .dev_clear(dev_clear), .serial_poll(serial_poll),
        .pending_ops(pending_ops), .std_event_set(8'h00),
        .oper_summary(oper_summary), .ques_summary(ques_summary),
        .msg_avail(msg_avail), .opt_installed(opt_installed),
        .inst_state(inst_state), .cmd_ready(cmd_ready),
        .resp_valid(resp_valid), .resp_data(resp_data),
        .poll_valid(poll_valid), .poll_data(poll_data), .srq(srq),
        .status_byte(status_byte), .settings_load(settings_load),
        .settings_word(settings_word), .cal_off(cal_off),
        .trig_abort(trig_abort), .bus_trigger(bus_trigger),
        .clear_status(clear_status), .hold_off(hold_off));

    // ------------------------------------------------------------
    // monitors: pulses are counted so no single edge is missed
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (resp_valid === 1'b1) resp_q.push_back(resp_data);
        if (poll_valid === 1'b1) poll_last = poll_data;
        n_trig += int'(bus_trigger === 1'b1);
        n_clr  += int'(clear_status === 1'b1);
        n_load += int'(settings_load === 1'b1);
        n_cal  += int'(cal_off === 1'b1 && trig_abort === 1'b1);
    end

    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmpw(input logic [STATE_W-1:0] g,
                        input logic [STATE_W-1:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmd(input logic [3:0] op, input logic [7:0] arg);
        i_ccs_ctrl_model.send(op, arg);
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic query(input logic [3:0] op, output logic [7:0] r);
        resp_q.delete();
        cmd(op, 8'h00);
        r = (resp_q.size() > 0) ? resp_q[0] : 8'hXX;
    endtask

    task automatic do_reset();
        arst_n = 1'b0;
        repeat (20) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_psc();
        cmd(OP_PSC, 8'h00);
        cmd(OP_SRE, 8'h5A);
        cmd(OP_ESE, 8'h81);
        do_reset();
        query(OP_SRE_Q, d); cmp8(d, 8'h5A);
        query(OP_ESE_Q, d); cmp8(d, 8'h81);
        cmd(OP_PSC, 8'h01);
        query(OP_PSC_Q, d); cmp8(d, 8'h01);
        do_reset();
        query(OP_SRE_Q, d); cmp8(d, 8'h00);
        query(OP_ESE_Q, d); cmp8(d, 8'h00);
    endtask

    task automatic t_opt();
        opt_installed = 14'h2A5;
        resp_q.delete();
        i_ccs_ctrl_model.send(OP_OPT_Q, 8'h00);
        repeat (18) @(posedge mclk);
        #1;
        cmp8(8'(resp_q.size()), 8'h0E);
        for (int i = 0; i < NUM_OPT; i++) begin
            d = (resp_q.size() > i) ? resp_q[i] : 8'hXX;
            cmp8(d, opt_installed[i] ? 8'(i + 1) : 8'h00);
        end
    endtask

    task automatic t_savrcl();
        inst_state = 47'h1234_5678_9ABC;
        cmd(OP_SAV, 8'h03);
        inst_state = 47'h6DCB_A987_6543;
        cmd(OP_SAV, 8'h07);
        n_cal = 0;
        cmd(OP_RCL, 8'h03);
        cmpw(settings_word, 47'h1234_5678_9ABC);
        cmp8(8'(n_cal), 8'h01);
        cmd(OP_SRE, 8'h5A);
        n_clr = 0;
        cmd(OP_RST, 8'h00);
        cmpw(settings_word, dflt);
        cmp8(8'(n_clr), 8'h01);
        query(OP_SRE_Q, d); cmp8(d, 8'h5A);
        cmd(OP_RCL, 8'h07);
        cmpw(settings_word, 47'h6DCB_A987_6543);
        n_load = 0;
        cmd(OP_RCL, 8'h08);
        cmp8(8'(n_load), 8'h00);
    endtask

    task automatic t_trg();
        n_trig = 0;
        cmd(OP_TRG, 8'h00);
        cmp8(8'(n_trig), 8'h01);
        n_clr = 0;
        @(posedge mclk);
        #1;
        dev_clear = 1'b1;
        @(posedge mclk);
        #1;
        dev_clear = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        cmp8(8'(n_clr), 8'h01);
        cmpw(settings_word, dflt);
    endtask

    task automatic t_stb();
        oper_summary = 1'b1;
        ques_summary = 1'b1;
        msg_avail = 1'b1;
        cmd(OP_SRE, 8'h00);
        query(OP_STB_Q, d); cmp8(d, 8'h98);
        cmp8({7'h00, srq}, 8'h00);
        query(OP_STB_Q, d); cmp8(d, 8'h98);
        cmd(OP_SRE, 8'h08);
        cmp8({7'h00, srq}, 8'h01);
        query(OP_STB_Q, d); cmp8(d, 8'hD8);
        cmp8(status_byte, 8'hD8);
        i_ccs_ctrl_model.poll();
        repeat (2) @(posedge mclk);
        #1;
        cmp8(poll_last, 8'hD8);
        cmp8({7'h00, srq}, 8'h00);
        query(OP_STB_Q, d); cmp8(d, 8'hD8);
        i_ccs_ctrl_model.poll();
        repeat (2) @(posedge mclk);
        #1;
        cmp8(poll_last, 8'h98);
    endtask

    task automatic t_wai();
        pending_ops = 1'b1;
        cmd(OP_WAI, 8'h00);
        cmp8({7'h00, hold_off}, 8'h01);
        query(OP_SRE_Q, d); cmp8({7'h00, hold_off}, 8'h00);
        query(OP_ESR_Q, d);
        cmd(OP_OPC, 8'h00);
        query(OP_ESR_Q, d); cmp8(d & 8'h01, 8'h00);
        pending_ops = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        query(OP_ESR_Q, d); cmp8(d & 8'h01, 8'h01);
    endtask

    task automatic test_done();
        $display("fails %0d check_count %0d", fails, check_count);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // counts kept small; watchdog far beyond the few hundred cycles
    initial begin
        #2000000;
        fails++;
        test_done();
    end

    initial begin
        dflt = '0;
        dflt[SW_LIST] = 1'b1;
        dflt[SW_PDLY +: 16] = 16'h0064;
        dflt[SW_FREQ +: 16] = 16'h003C;
        dflt[SW_TSRC] = 1'b1;
        dflt[SW_SSRC] = 1'b1;
        dflt[SW_SLEW] = 1'b1;
        do_reset();
        t_psc();
        t_opt();
        t_savrcl();
        t_trg();
        t_stb();
        t_wai();
        test_done();
    end
endmodule
